// *** rtl/blinds_pushbutton_input.v ***
// Blinds push-button input channel with an AXI4-Lite register port.
// Assumes contact and block telegram inputs are synchronous to aclk.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "blinds_regs.vh"
module blinds_pushbutton_input #(
  parameter [15:0] TICK_CYCLES = `MS_CYCLES
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire awvalid,
  output reg awready,
  input wire [3:0] awaddr,
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read
  input wire arvalid,
  output reg arready,
  input wire [3:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Contact and received block telegram
  input wire contact,
  input wire block_valid,
  input wire block_value,
  // Outgoing telegrams
  output reg step_valid,
  output reg step_dir,
  output reg move_valid,
  output reg move_dir
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PRESS = 3'h1;
  localparam [2:0] S_LONG = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_HOLD = 3'h4;

  reg [31:0] cfg;
  reg [15:0] tick_cnt;
  reg tick;
  reg stable;
  reg blocked;
  reg moving;
  reg last_dir;
  reg restore_pend;
  reg [2:0] st;
  reg [2:0] next_st;
  reg aw_full;
  reg w_full;
  reg [3:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] strb_q;
  wire [13:0] db_cnt;
  wire [13:0] pr_cnt;
  wire [13:0] win_cnt;
  wire [13:0] rs_cnt;
  wire do_wr;
  wire restart;
  wire [31:0] mask;
  wire enabled;
  wire [1:0] op;
  wire stop_rel;

  function [13:0] deb_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: deb_ms = `DEB_30_MS;
        3'h1: deb_ms = `DEB_50_MS;
        3'h2: deb_ms = `DEB_80_MS;
        3'h3: deb_ms = `DEB_100_MS;
        3'h4: deb_ms = `DEB_200_MS;
        3'h5: deb_ms = `DEB_1_S;
        3'h6: deb_ms = `DEB_5_S;
        default: deb_ms = `DEB_10_S;
      endcase
    end
  endfunction

  // Both press thresholds run from 300 ms to 1 s in 100 ms steps.
  function [13:0] win_ms;
    input [2:0] sel;
    begin
      win_ms = `WIN_BASE_MS + ({11'h000, sel} * `WIN_STEP_MS);
    end
  endfunction

  function [13:0] rst_ms;
    input [3:0] sel;
    begin
      case (sel)
        4'h3, 4'h6: rst_ms = `RST_5_S;
        4'h4, 4'h7: rst_ms = `RST_10_S;
        4'h5, 4'h8: rst_ms = `RST_15_S;
        default: rst_ms = 14'h0000;
      endcase
    end
  endfunction

  assign enabled = cfg[`CFG_ACTIVE] &&
    cfg[`CFG_FUNC_HI:`CFG_FUNC_LO] == `FUNC_BLINDS;
  assign op = cfg[`CFG_OP_HI:`CFG_OP_LO];
  assign stop_rel = cfg[`CFG_STOP_REL];

  // Millisecond time base shared by all timers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  ms_timer u_db (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(contact == stable),
    .count(db_cnt)
  );
  ms_timer u_press (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(st != S_PRESS),
    .count(pr_cnt)
  );
  ms_timer u_win (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(st != S_WAIT),
    .count(win_cnt)
  );
  ms_timer u_rst (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(restart),
    .count(rs_cnt)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      stable <= 1'b0;
    end else if (contact != stable &&
                 db_cnt >= deb_ms(cfg[`CFG_DEB_HI:`CFG_DEB_LO])) begin
      stable <= contact;
    end
  end

  // Block handling: polarity, enable and the set and cancel edges.
  reg next_blocked;
  reg blk_set;
  reg blk_clr;
  always @* begin
    next_blocked = blocked;
    if (!cfg[`CFG_BLK_EN] ||
        cfg[`CFG_BSET_HI:`CFG_BSET_LO] == `BSET_IGNORE) begin
      next_blocked = 1'b0;
    end else if (block_valid) begin
      next_blocked = block_value ^ cfg[`CFG_BLK_INV];
    end
    blk_set = next_blocked && !blocked;
    blk_clr = !next_blocked && blocked && cfg[`CFG_BLK_EN];
  end

  wire [3:0] rst_sel = cfg[`CFG_RST_HI:`CFG_RST_LO];
  wire rst_fire = restore_pend &&
    rs_cnt >= rst_ms(rst_sel);
  wire rst_up = rst_sel == 4'h1 || rst_sel == 4'h3 ||
    rst_sel == 4'h4 || rst_sel == 4'h5;
  wire rst_dn = rst_sel == 4'h2 || rst_sel == 4'h6 ||
    rst_sel == 4'h7 || rst_sel == 4'h8;

  // Press state machine and telegram selection.
  reg ev_valid;
  reg ev_move;
  reg ev_dir;
  reg next_moving;
  reg next_last;
  reg short_dir;
  reg [1:0] act;
  always @* begin
    next_st = st;
    ev_valid = 1'b0;
    ev_move = 1'b0;
    ev_dir = 1'b0;
    next_moving = moving;
    next_last = last_dir;
    act = 2'h0;
    case (op)
      `OP_DOWN: short_dir = 1'b1;
      `OP_UP: short_dir = 1'b0;
      default: short_dir = !last_dir;
    endcase
    case (st)
      S_IDLE: begin
        if (stable) begin
          next_st = S_PRESS;
        end
      end
      S_PRESS: begin
        if (!stable) begin
          if (cfg[`CFG_DC_EN]) begin
            next_st = S_WAIT;
          end else begin
            next_st = S_IDLE;
            ev_valid = 1'b1;
          end
        end else if (pr_cnt >= win_ms(cfg[`CFG_LONG_HI:`CFG_LONG_LO])) begin
          next_st = S_LONG;
          ev_valid = 1'b1;
          ev_move = 1'b1;
        end
      end
      S_LONG: begin
        if (!stable) begin
          next_st = S_IDLE;
          if (stop_rel && moving) begin
            ev_valid = 1'b1;
            ev_dir = last_dir;
            next_moving = 1'b0;
          end
        end
      end
      S_WAIT: begin
        if (stable) begin
          next_st = S_HOLD;
          act = cfg[`CFG_DCA_HI:`CFG_DCA_LO];
        end else if (win_cnt >= win_ms(cfg[`CFG_DC_HI:`CFG_DC_LO])) begin
          next_st = S_IDLE;
          ev_valid = 1'b1;
        end
      end
      S_HOLD: begin
        if (!stable) begin
          next_st = S_IDLE;
        end
      end
      default: next_st = S_IDLE;
    endcase
    // A short press either steps or, while moving with stop_rel clear, stops the movement.
    if (ev_valid && !ev_move && !(st == S_LONG)) begin
      if (moving && !stop_rel) begin
        ev_dir = last_dir;
        next_moving = 1'b0;
      end else begin
        ev_dir = short_dir;
        next_last = short_dir;
      end
    end
    if (ev_move) begin
      ev_dir = short_dir;
      next_last = short_dir;
      next_moving = 1'b1;
    end
    if (!enabled || blocked) begin
      next_st = S_IDLE;
      ev_valid = 1'b0;
      ev_move = 1'b0;
      next_moving = moving;
      next_last = last_dir;
      act = 2'h0;
    end
    // Block edges and restoration outrank press telegrams.
    if (blk_set) begin
      // Set codes: 2 raises, 3 lowers, anything else sends nothing.
      case (cfg[`CFG_BSET_HI:`CFG_BSET_LO])
        2'h2: act = `ACT_UP;
        2'h3: act = `ACT_DOWN;
        default: act = 2'h0;
      endcase
    end else if (blk_clr) begin
      act = cfg[`CFG_BCLR_HI:`CFG_BCLR_LO];
    end else if (rst_fire) begin
      act = rst_up ? `ACT_UP : (rst_dn ? `ACT_DOWN : 2'h0);
    end
    if ((blk_set || blk_clr || rst_fire) && !enabled) begin
      act = 2'h0;
    end
    if (act == `ACT_UP || act == `ACT_DOWN) begin
      ev_valid = 1'b1;
      ev_move = 1'b1;
      ev_dir = act == `ACT_DOWN;
      next_last = act == `ACT_DOWN;
      next_moving = 1'b1;
    end else if (blk_set || blk_clr || rst_fire) begin
      ev_valid = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st <= S_IDLE;
      blocked <= 1'b0;
      moving <= 1'b0;
      last_dir <= 1'b0;
      restore_pend <= 1'b1;
      step_valid <= 1'b0;
      step_dir <= 1'b0;
      move_valid <= 1'b0;
      move_dir <= 1'b0;
    end else begin
      st <= next_st;
      blocked <= next_blocked;
      moving <= next_moving;
      last_dir <= next_last;
      if (restart) begin
        restore_pend <= 1'b1;
      end else if (rst_fire) begin
        restore_pend <= 1'b0;
      end
      step_valid <= ev_valid && !ev_move;
      move_valid <= ev_valid && ev_move;
      if (ev_valid && !ev_move) begin
        step_dir <= ev_dir;
      end
      if (ev_valid && ev_move) begin
        move_dir <= ev_dir;
      end
    end
  end

  // AXI4-Lite slave; address and data are taken in either order.
  assign do_wr = aw_full && w_full && !bvalid;
  assign restart = do_wr && aw_q[3:2] == `REG_CTRL &&
    strb_q[0] && w_q[0];
  assign mask = {{8{strb_q[3]}}, {8{strb_q[2]}},
    {8{strb_q[1]}}, {8{strb_q[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h00000000;
      strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      cfg <= `CFG_RESET;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_q <= awaddr;
        awready <= 1'b0;
      end else if (!aw_full && !do_wr) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        w_q <= wdata;
        strb_q <= wstrb;
        wready <= 1'b0;
      end else if (!w_full && !do_wr) begin
        wready <= 1'b1;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= aw_q[3:2] == 2'h3 ? 2'h2 : 2'h0;
        if (aw_q[3:2] == `REG_CFG) begin
          cfg <= (cfg & ~mask) | (w_q & mask);
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= araddr[3:2] == 2'h3 ? 2'h2 : 2'h0;
      case (araddr[3:2])
        `REG_CFG: rdata <= cfg;
        `REG_STATUS: rdata <= {24'h000000, st, last_dir,
          restore_pend, moving, blocked, stable};
        default: rdata <= 32'h00000000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
endmodule

// *** rtl/blinds_regs.vh ***
// Constants for the blinds push-button input channel: register offsets,
// configuration field positions, reset values and timing figures.
// Assumes a 40 MHz system clock and an AXI4-Lite register port.

`ifndef BLINDS_REGS_VH
`define BLINDS_REGS_VH

`define CLK_PERIOD_NS 25
`define MS_NS 1000000
// Clock cycles in one millisecond at 40 MHz.
`define MS_CYCLES 16'h9C40

`define REG_CFG 2'h0
`define REG_STATUS 2'h1
`define REG_CTRL 2'h2
`define CFG_RESET 32'h00000008

`define CFG_ACTIVE 0
`define CFG_FUNC_LO 1
`define CFG_FUNC_HI 2
`define CFG_DEB_LO 3
`define CFG_DEB_HI 5
`define CFG_LONG_LO 6
`define CFG_LONG_HI 8
`define CFG_DC_EN 9
`define CFG_DC_LO 10
`define CFG_DC_HI 12
`define CFG_BLK_EN 13
`define CFG_BLK_INV 14
`define CFG_OP_LO 15
`define CFG_OP_HI 16
`define CFG_STOP_REL 17
`define CFG_RST_LO 18
`define CFG_RST_HI 21
`define CFG_BSET_LO 22
`define CFG_BSET_HI 23
`define CFG_BCLR_LO 24
`define CFG_BCLR_HI 25
`define CFG_DCA_LO 26
`define CFG_DCA_HI 27

`define FUNC_BLINDS 2'h3
`define OP_ONE 2'h0
`define OP_DOWN 2'h1
`define OP_UP 2'h2
`define BSET_IGNORE 2'h0
`define ACT_UP 2'h1
`define ACT_DOWN 2'h2
`define ACT_LOWER 2'h3

`define DEB_30_MS 14'h001E
`define DEB_50_MS 14'h0032
`define DEB_80_MS 14'h0050
`define DEB_100_MS 14'h0064
`define DEB_200_MS 14'h00C8
`define DEB_1_S 14'h03E8
`define DEB_5_S 14'h1388
`define DEB_10_S 14'h2710
`define WIN_BASE_MS 14'h012C
`define WIN_STEP_MS 14'h0064
`define RST_5_S 14'h1388
`define RST_10_S 14'h2710
`define RST_15_S 14'h3A98

`endif

// *** rtl/ms_timer.v ***
// Saturating millisecond counter used for every timed decision.
// Assumes tick is a one-cycle pulse once per millisecond.
`timescale 1ns/1ps
module ms_timer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire tick,
  input wire clear,
  // Elapsed milliseconds
  output reg [13:0] count
);
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= 14'h0000;
    end else if (tick && count != 14'h3FFF) begin
      count <= count + 14'h0001;
    end
  end
endmodule

// *** bench/blinds_pushbutton_input_assertions.sv ***
// Port-level checker for the blinds push-button channel.
// Assumes it is bound to blinds_pushbutton_input and sees only its ports.
`timescale 1ns/1ps
module blinds_pushbutton_input_assertions (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [1:0] bresp,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  // Telegrams
  input wire step_valid,
  input wire step_dir,
  input wire move_valid,
  input wire move_dir
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read data late");
  a_bresp_stands: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write response dropped");
  a_rdata_stands: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read data dropped");
  a_step_one_cycle: assert property (step_valid |=> !step_valid)
    else $error("step pulse too long");
  a_move_one_cycle: assert property (move_valid |=> !move_valid)
    else $error("move pulse too long");
  a_one_object: assert property (!(step_valid && move_valid))
    else $error("two telegrams in one cycle");
  a_step_dir_hold: assert property ($changed(step_dir) |-> step_valid)
    else $error("step direction moved alone");
  a_move_dir_hold: assert property ($changed(move_dir) |-> move_valid)
    else $error("move direction moved alone");
  a_resp_codes: assert property (rvalid |-> rresp == 2'h0 || rresp == 2'h2)
    else $error("bad read response code");
endmodule
bind blinds_pushbutton_input blinds_pushbutton_input_assertions i_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp,
  .step_valid, .step_dir, .move_valid, .move_dir);

// *** bench/blinds_actuator_model.sv ***
// Blinds actuator model that tallies the step and move telegrams.
// Assumes telegram pulses last one clock cycle.
`timescale 1ns/1ps
module blinds_actuator_model (
  // Clock
  input wire aclk,
  // Telegrams
  input wire step_valid,
  input wire step_dir,
  input wire move_valid,
  input wire move_dir,
  // Tally
  output int n_step,
  output int n_move,
  output logic last_dir
);
  initial begin
    n_step = 0;
    n_move = 0;
    last_dir = 1'h0;
  end
  always @(posedge aclk) begin
    if (step_valid) begin
      n_step <= n_step + 1;
      last_dir <= step_dir;
    end
    if (move_valid) begin
      n_move <= n_move + 1;
      last_dir <= move_dir;
    end
  end
endmodule

// *** bench/blinds_pushbutton_input_tb_top.sv ***
// Testbench for the blinds channel: bus master, contact and block stimulus.
// Assumes a 40 MHz clock and a 4-cycle millisecond tick.
`timescale 1ns/1ps
module blinds_pushbutton_input_tb_top;
  localparam int TK = 4;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  logic contact = 1'h0, block_valid = 1'h0, block_value = 1'h0;
  logic step_valid, step_dir, move_valid, move_dir, last_dir;
  int n_step, n_move, s0, m0, n_mismatch = 0, num_checks = 0;
  blinds_pushbutton_input #(.TICK_CYCLES(16'h0004)) i_blinds_pushbutton_input (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .contact, .block_valid, .block_value,
    .step_valid, .step_dir, .move_valid, .move_dir);
  blinds_actuator_model i_blinds_actuator_model (.aclk, .step_valid,
    .step_dir, .move_valid, .move_dir, .n_step, .n_move, .last_dir);
  always #12.5 aclk = ~aclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task ms(input int n);
    repeat (n * TK) @(posedge aclk);
  endtask
  task mark;
    s0 = n_step;
    m0 = n_move;
  endtask
  // A negative move count means either object may carry the telegram.
  task tally(input int dall, input int dm, input logic d);
    chk(n_step + n_move - s0 - m0, dall);
    if (dm >= 0) chk(n_move - m0, dm);
    if (dall > 0) chk(last_dir, d);
    mark;
  endtask
  task press(input int on);
    contact <= 1'h1;
    ms(on);
    contact <= 1'h0;
    ms(100);
  endtask
  task blk(input logic v);
    block_value <= v;
    block_valid <= 1'h1;
    @(posedge aclk);
    block_valid <= 1'h0;
    ms(10);
  endtask
  task t_regs;
    axi_rd(4'h0);
    chk(rd, 32'h00000008);
    axi_rd(4'hC);
    chk(rr, 2'h2);
    axi_wr(4'hC, 32'hFFFFFFFF);
    chk(rr, 2'h2);
    $display("t_regs done");
  endtask
  task t_inactive;
    axi_wr(4'h0, 32'h00028006);
    mark;
    press(500);
    tally(0, 0, 1'h0);
    $display("t_inactive done");
  endtask
  task t_down;
    axi_wr(4'h0, 32'h00028007);
    mark;
    press(100);
    tally(1, 0, 1'h1);
    press(500);
    tally(2, 1, 1'h1);
    $display("t_down done");
  endtask
  task t_up;
    axi_wr(4'h0, 32'h00010007);
    mark;
    press(500);
    tally(1, 1, 1'h0);
    press(100);
    tally(1, 0, 1'h0);
    $display("t_up done");
  endtask
  task t_one;
    axi_wr(4'h0, 32'h00000007);
    mark;
    press(500);
    tally(1, 1, 1'h1);
    press(100);
    tally(1, 0, 1'h1);
    $display("t_one done");
  endtask
  task t_block;
    axi_wr(4'h0, 32'h00028007);
    mark;
    blk(1'h1);
    press(100);
    tally(1, 0, 1'h1);
    axi_wr(4'h0, 32'h01C2A007);
    blk(1'h0);
    mark;
    blk(1'h1);
    tally(1, -1, 1'h1);
    press(500);
    tally(0, 0, 1'h0);
    blk(1'h0);
    tally(1, -1, 1'h0);
    axi_wr(4'h0, 32'h0282E007);
    ms(10);
    mark;
    blk(1'h0);
    tally(1, -1, 1'h0);
    blk(1'h1);
    tally(1, -1, 1'h1);
    $display("t_block done");
  endtask
  task t_restore;
    axi_wr(4'h0, 32'h000A8007);
    mark;
    axi_wr(4'h8, 32'h00000001);
    ms(20);
    tally(1, -1, 1'h1);
    axi_wr(4'h0, 32'h000E8007);
    axi_wr(4'h8, 32'h00000001);
    mark;
    ms(4900);
    tally(0, 0, 1'h0);
    ms(300);
    tally(1, -1, 1'h0);
    $display("t_restore done");
  endtask
  task t_debounce;
    axi_wr(4'h0, 32'h00028027);
    mark;
    press(150);
    tally(0, 0, 1'h0);
    press(250);
    ms(150);
    tally(1, 0, 1'h1);
    $display("t_debounce done");
  endtask
  task t_double;
    axi_wr(4'h0, 32'h04028207);
    mark;
    press(100);
    press(100);
    tally(1, 1, 1'h0);
    press(100);
    ms(300);
    tally(1, 0, 1'h1);
    axi_wr(4'h0, 32'h04028007);
    press(100);
    press(100);
    tally(2, 0, 1'h1);
    $display("t_double done");
  endtask
  initial begin
    repeat (80000) @(posedge aclk);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_inactive;
    t_down;
    t_up;
    t_one;
    t_block;
    t_debounce;
    t_double;
    t_restore;
    close_out;
  end
endmodule
